// [acs_pkg.sv]
// constants and types shared by the converter control block
// assumes a single 100 MHz clock and serial pins already in that domain
`default_nettype none

package acs_pkg;

  localparam int CFG_W      = 12;
  localparam int WORD_W     = 16;
  localparam int RES_W      = 10;
  localparam int CMD_W      = 4;
  localparam int CNT_W      = 5;
  localparam int FIFO_DEPTH = 32;

  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

  // configuration field positions
  localparam int F_REF_INT   = 11;
  localparam int F_TWOS      = 10;
  localparam int F_LONG_SAMP = 9;
  localparam int F_CLK_DIV2  = 8;
  localparam int F_PSEUDO    = 7;
  localparam int F_MODE_HI   = 6;
  localparam int F_MODE_LO   = 5;
  localparam int F_SEQ_HI    = 4;
  localparam int F_SEQ_LO    = 3;
  localparam int F_PIN_EOC   = 2;
  localparam int F_TRIG_HI   = 1;
  localparam int F_TRIG_LO   = 0;

  localparam logic [1:0] MODE_ONE_SHOT = 2'h0;

  // command codes in the top four bits of a frame
  localparam logic [CMD_W-1:0] CMD_CH_LAST  = 4'h7;
  localparam logic [CMD_W-1:0] CMD_PWR_DOWN = 4'h8;
  localparam logic [CMD_W-1:0] CMD_CFG_RD   = 4'h9;
  localparam logic [CMD_W-1:0] CMD_CFG_WR   = 4'hA;
  localparam logic [CMD_W-1:0] CMD_TEST_LO  = 4'hB;
  localparam logic [CMD_W-1:0] CMD_TEST_HI  = 4'hD;
  localparam logic [CMD_W-1:0] CMD_FIFO_RD  = 4'hE;

  // serial edge counts
  localparam logic [CNT_W-1:0] CMD_BITS    = 5'h04;
  localparam logic [CNT_W-1:0] SHORT_EDGE  = 5'h10;
  localparam logic [CNT_W-1:0] LONG_EDGE   = 5'h1C;
  localparam logic [CNT_W-1:0] WORD_BITS   = 5'h10;
  localparam logic [CNT_W-1:0] CONV_CLOCKS = 5'h0A;

  localparam logic [RES_W-1:0] SIGN_FLIP = 10'h200;
  localparam logic [5:0]       PAD_ZERO  = 6'h00;
  localparam logic [CMD_W-1:0] RD_PAD    = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SAMPLE  = 3'b001,
    ST_EXT     = 3'b010,
    ST_CONVERT = 3'b011,
    ST_STORE   = 3'b100
  } acs_state_t;

endpackage : acs_pkg

`default_nettype wire

// [acs_fifo.sv]
// result buffer: flip-flop FIFO with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`default_nettype none

module acs_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             flush_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [$clog2(DEPTH):0] count_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } acs_fifo_st_t;

  acs_fifo_st_t st_reg;
  acs_fifo_st_t st_next;
  logic         push;
  logic         pop;

  assign in_ready_out  = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid_out = (st_reg.count != '0);
  assign out_data_out  = st_reg.mem[st_reg.rd_ptr];
  assign count_out     = st_reg.count;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wr_ptr] = in_data_in;
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop)
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    if (push && !pop)
      st_next.count = st_reg.count + 1'b1;
    else if (pop && !push)
      st_next.count = st_reg.count - 1'b1;
    if (flush_in)
    begin
      st_next.wr_ptr = '0;
      st_next.rd_ptr = '0;
      st_next.count  = '0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

endmodule : acs_fifo

`default_nettype wire

// [acs_ctrl.sv]
// serial configuration, sampling and conversion control of the converter
// assumes serial pins are synchronous to clk_in and sclk is far slower
`default_nettype none

module acs_ctrl
  import acs_pkg::*;
#(
  parameter bit FOUR_INPUT = 1'b0
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 cs_n_in,
  input  wire logic                 sclk_in,
  input  wire logic                 sdi_in,
  input  wire logic                 frame_sync_input_in,
  input  wire logic                 sample_start_pin_n_in,
  input  wire logic [acs_pkg::RES_W-1:0] adc_result_in,
  output logic                      sdo_out,
  output logic                      sdo_oe_out,
  output logic                      status_pin_out,
  output logic                      ref_internal_out,
  output logic                      pseudo_diff_out,
  output logic [acs_pkg::CMD_W-1:0] mux_sel_out,
  output logic                      sampling_out,
  output logic                      converting_out,
  output logic                      powerdown_out
);
  import acs_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0]  cfg;
    logic [WORD_W-1:0] sh_out;
    logic [WORD_W-1:0] sh_in;
    logic [CNT_W-1:0]  bits;
    logic [CNT_W-1:0]  conv_cnt;
    logic              in_frame;
    logic              dsp_mode;
    logic              sclk_q;
    logic              cs_q;
    logic              fs_q;
    logic              ss_q;
    logic              ext_trig;
    logic              div;
    acs_state_t        state;
    logic [RES_W-1:0]  result;
    logic [CMD_W-1:0]  mux;
    logic [2:0]        sweep_idx;
    logic              thresh;
    logic              pwr_dn;
    logic              sdo;
  } acs_st_t;

  acs_st_t st_reg;
  acs_st_t st_next;

  logic [1:0]       mode;
  logic             sweep;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             in_edge;
  logic             out_edge;
  logic             spi_start;
  logic             dsp_start;
  logic             frame_start;
  logic [WORD_W-1:0] shifted;
  logic [CMD_W-1:0] cmd_now;
  logic             cmd_done;
  logic             conv_cmd;
  logic             cfg_wr;
  logic             cfg_rd;
  logic             fifo_rd;
  logic             ss_fall;
  logic             ss_rise;
  logic             conv_tick;
  logic [RES_W-1:0] coded;
  logic [CNT_W-1:0] trig_edge;
  logic [5:0]       level;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [RES_W-1:0] fifo_head;
  logic [5:0]       fifo_count;

  // channel order of an automatic sweep, for either part size
  function automatic logic [2:0] seq_chan(input logic [1:0] sel,
                                          input logic [2:0] i);
    logic [2:0] c;
    c = i;
    if (FOUR_INPUT)
    begin
      unique case (sel)
        2'b10:   c = {1'b0, i[2:1]};
        2'b11:   c = {2'b00, i[0]};
        default: c = {1'b0, i[1:0]};
      endcase
    end
    else
    begin
      unique case (sel)
        2'b00: c = i;
        2'b01: c = {i[1:0], 1'b0};
        2'b10: c = (i < 3'h2) ? 3'h0 : (i < 3'h4) ? 3'h2 :
                   (i == 3'h4) ? 3'h4 : 3'h6;
        2'b11: c = {1'b0, i[0], 1'b0};
      endcase
    end
    return c;
  endfunction : seq_chan

  assign mode      = st_reg.cfg[F_MODE_HI:F_MODE_LO];
  assign sweep     = mode[1];
  assign sclk_rise = sclk_in && !st_reg.sclk_q;
  assign sclk_fall = !sclk_in && st_reg.sclk_q;
  // spi shifts in on rising edges, dsp framing on falling edges
  assign in_edge   = st_reg.dsp_mode ? sclk_fall : sclk_rise;
  assign out_edge  = st_reg.dsp_mode ? sclk_rise : sclk_fall;
  assign spi_start = !cs_n_in && st_reg.cs_q && frame_sync_input_in;
  // frame sync restarts a frame even with chip select held low
  assign dsp_start = !cs_n_in && !frame_sync_input_in
                     && st_reg.fs_q;
  assign frame_start = spi_start || dsp_start;
  assign shifted   = {st_reg.sh_in[WORD_W-2:0], sdi_in};
  assign cmd_now   = shifted[CMD_W-1:0];
  assign cmd_done  = st_reg.in_frame && in_edge
                     && (st_reg.bits + 1'b1 == CMD_BITS);
  assign conv_cmd  = (cmd_now <= CMD_CH_LAST)
                     || (cmd_now >= CMD_TEST_LO && cmd_now <= CMD_TEST_HI);
  assign cfg_wr    = st_reg.in_frame && in_edge
                     && (st_reg.bits + 1'b1 == WORD_BITS)
                     && (shifted[WORD_W-1 -: CMD_W] == CMD_CFG_WR);
  assign cfg_rd    = cmd_done && cmd_now == CMD_CFG_RD
                     && mode == MODE_ONE_SHOT;
  assign fifo_rd   = cmd_done && cmd_now == CMD_FIFO_RD;
  // the start pin's falling edge counts only with the serial port deselected
  assign ss_fall   = !sample_start_pin_n_in && st_reg.ss_q
                     && cs_n_in;
  assign ss_rise   = sample_start_pin_n_in && !st_reg.ss_q;
  assign trig_edge = st_reg.cfg[F_LONG_SAMP] ? LONG_EDGE
                                             : SHORT_EDGE;
  // extended conversions run free of the serial clock
  assign conv_tick = st_reg.ext_trig ? 1'b1 :
                     (sclk_rise && (!st_reg.cfg[F_CLK_DIV2]
                                    || st_reg.div));
  assign coded     = st_reg.cfg[F_TWOS] ? (adc_result_in ^ SIGN_FLIP)
                                        : adc_result_in;
  assign level     = {2'b00, ~st_reg.cfg[F_TRIG_HI:F_TRIG_LO], 1'b0}
                     + 6'h02;

  acs_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .flush_in      (1'b0),
    .in_data_in    (st_reg.result),
    .in_valid_in   (st_reg.state == ST_STORE && sweep_or_repeat()),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (fifo_head),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_rd),
    .count_out     (fifo_count)
  );

  function automatic logic sweep_or_repeat();
    return mode != MODE_ONE_SHOT;
  endfunction : sweep_or_repeat

  always_comb
  begin
    st_next        = st_reg;
    st_next.sclk_q = sclk_in;
    st_next.cs_q   = cs_n_in;
    st_next.fs_q   = frame_sync_input_in;
    st_next.ss_q   = sample_start_pin_n_in;

    if (cs_n_in)
      st_next.in_frame = 1'b0;
    if (frame_start)
    begin
      st_next.in_frame = 1'b1;
      st_next.dsp_mode = dsp_start;
      st_next.bits     = '0;
      st_next.thresh   = 1'b0;
      st_next.pwr_dn   = 1'b0;
      // a held result leaves on the next cycle, fifo data first
      st_next.sh_out   = (sweep_or_repeat() && fifo_out_valid)
                         ? {fifo_head, PAD_ZERO}
                         : {st_reg.result, PAD_ZERO};
      st_next.sdo      = st_next.sh_out[WORD_W-1];
    end
    else if (st_reg.in_frame)
    begin
      // a stalled serial clock simply leaves the count waiting; edges are
      // counted on past the data word so long sampling can reach its end
      if (in_edge && st_reg.bits != LONG_EDGE)
        st_next.bits  = st_reg.bits + 1'b1;
      if (in_edge && st_reg.bits < WORD_BITS)
        st_next.sh_in = shifted;
      if (out_edge && st_reg.bits < WORD_BITS)
      begin
        st_next.sh_out = {st_reg.sh_out[WORD_W-2:0], 1'b0};
        st_next.sdo    = st_reg.sh_out[WORD_W-2];
      end
      // four bits have already left by the fourth input bit
      if (cfg_rd)
        st_next.sh_out = {RD_PAD[0], st_reg.cfg,
                          RD_PAD[CMD_W-2:0]};
      if (cmd_done && cmd_now == CMD_PWR_DOWN)
        st_next.pwr_dn = 1'b1;
      if (cmd_done && conv_cmd && st_reg.state == ST_IDLE)
      begin
        st_next.state    = ST_SAMPLE;
        st_next.ext_trig = 1'b0;
        st_next.mux      = sweep
          ? {1'b0, seq_chan(st_reg.cfg[F_SEQ_HI:F_SEQ_LO],
                            st_reg.sweep_idx)}
          : cmd_now;
      end
    end
    if (cfg_wr)
      st_next.cfg = shifted[CFG_W-1:0];

    unique case (st_reg.state)
      ST_IDLE:
        if (ss_fall)
        begin
          st_next.state    = ST_EXT;
          st_next.ext_trig = 1'b1;
        end
      ST_SAMPLE:
        if (in_edge && st_reg.bits + 1'b1 == trig_edge)
        begin
          st_next.state    = ST_CONVERT;
          st_next.conv_cnt = '0;
          st_next.div      = 1'b0;
        end
      ST_EXT:
        if (ss_rise)
        begin
          st_next.state    = ST_CONVERT;
          st_next.conv_cnt = '0;
        end
      ST_CONVERT:
      begin
        if (sclk_rise)
          st_next.div = !st_reg.div;
        if (conv_tick)
          st_next.conv_cnt = st_reg.conv_cnt + 1'b1;
        if (conv_tick && st_reg.conv_cnt + 1'b1 == CONV_CLOCKS)
        begin
          st_next.result = coded;
          st_next.state  = ST_STORE;
        end
      end
      ST_STORE:
        // back-pressure: hold here until the fifo takes the word
        if (!sweep_or_repeat() || fifo_in_ready)
        begin
          st_next.state = ST_IDLE;
          if (sweep)
            st_next.sweep_idx = (st_reg.sweep_idx + 1'b1 == level[2:0]
                                 || level == 6'h08
                                 && st_reg.sweep_idx == 3'h7)
                                ? 3'h0 : st_reg.sweep_idx + 1'b1;
          if (!sweep_or_repeat())
            st_next.thresh = 1'b1;
        end
      default:
        st_next.state = ST_IDLE;
    endcase
    // threshold set beats the frame-start clear
    if (sweep_or_repeat() && fifo_count >= level)
      st_next.thresh = 1'b1;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      st_reg        <= '0;
      st_reg.cfg    <= CFG_RESET;
      st_reg.sclk_q <= 1'b0;
      st_reg.cs_q   <= 1'b1;
      st_reg.fs_q   <= 1'b1;
      st_reg.ss_q   <= 1'b1;
      st_reg.state  <= ST_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign sdo_out          = st_reg.sdo;
  assign sdo_oe_out       = st_reg.in_frame && !cs_n_in
                            && st_reg.bits < WORD_BITS;
  assign status_pin_out   = st_reg.cfg[F_PIN_EOC]
                            ? (st_reg.state != ST_CONVERT)
                            : !st_reg.thresh;
  assign ref_internal_out = st_reg.cfg[F_REF_INT];
  assign pseudo_diff_out  = st_reg.cfg[F_PSEUDO];
  assign mux_sel_out      = st_reg.mux;
  assign sampling_out     = st_reg.state == ST_SAMPLE
                            || st_reg.state == ST_EXT;
  assign converting_out   = st_reg.state == ST_CONVERT;
  // power-down touches no configuration state
  assign powerdown_out    = st_reg.pwr_dn;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_cfg_hold_pd: assert property (powerdown_out && !cfg_wr |=>
    $stable(st_reg.cfg)) else $error("config changed in power-down");
  a_cfg_write: assert property (cfg_wr |=>
    st_reg.cfg == $past(shifted[CFG_W-1:0]))
    else $error("config write not stored");
  a_read_mode: assert property (cmd_done && cmd_now == CMD_CFG_RD
    && mode == MODE_ONE_SHOT |=> st_reg.sh_out[WORD_W-2 -: CFG_W]
    == $past(st_reg.cfg)) else $error("config read word not loaded");
  a_ref_select: assert property (cfg_wr |=> ref_internal_out ==
    $past(shifted[F_REF_INT])) else $error("reference select mismatch");
  a_result_code: assert property (st_reg.state == ST_CONVERT
    && st_next.state == ST_STORE |=> st_reg.result ==
    ($past(adc_result_in) ^ ($past(st_reg.cfg[F_TWOS]) ? SIGN_FLIP
    : 10'h000))) else $error("result coding wrong");
  a_sample_go: assert property (cmd_done && conv_cmd
    && st_reg.state == ST_IDLE |=> st_reg.state == ST_SAMPLE)
    else $error("sampling did not start");
  a_sample_end: assert property (st_reg.state == ST_SAMPLE
    && in_edge && st_reg.bits + 1'b1 == trig_edge |=> converting_out)
    else $error("conversion did not start on time");
  a_ext_gate: assert property (st_reg.state == ST_IDLE && !cs_n_in
    |=> st_reg.state != ST_EXT) else $error("start pin not ignored");
  a_ext_conv: assert property (st_reg.state == ST_EXT && ss_rise
    |=> converting_out) else $error("start pin rise ignored");
  a_eoc_pin: assert property (st_reg.cfg[F_PIN_EOC]
    |-> status_pin_out == !converting_out) else $error("eoc pin wrong");

endmodule : acs_ctrl

`default_nettype wire

// [acs_host_model.sv]
// host serial-port model: chip select, serial clock, data, frame sync, start
// assumes the bench calls its tasks; every pin moves on a falling clk_in edge
`default_nettype none

module acs_host_model (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out,
  output logic      fs_out,
  output logic      start_n_out
);
  int edge_cnt;

  initial
  begin
    cs_n_out    = 1'b1;
    sclk_out    = 1'b0;
    sdi_out     = 1'b0;
    fs_out      = 1'b1;
    start_n_out = 1'b1;
    edge_cnt    = 0;
  end

  // one frame of 56 serial clocks, long enough for the slowest conversion
  // spi shifts on sclk rise, dsp on fall; sclk stands still between frames
  task automatic xfer(input logic [15:0] w, input bit dsp, input bit pause,
                      input bit pulse, output logic [15:0] rd);
    logic act;
    act = ~dsp;
    @(negedge clk_in);
    sclk_out = ~act;
    cs_n_out = 1'b0;
    fs_out   = act;
    edge_cnt = 0;
    for (int i = 0; i < 56; i++)
    begin
      sdi_out     = (i < 16) ? w[15-i] : ~sdi_out;
      start_n_out = ~(pulse && i >= 2 && i < 14);
      repeat (4) @(negedge clk_in);
      if (i < 16)
        rd[15-i] = sdo_in;
      sclk_out = act;
      edge_cnt++;
      if (i == 0)
        fs_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sclk_out = ~act;
      if (pause && i == 7)
        repeat (40) @(negedge clk_in);
    end
    // a dsp host keeps the device selected between frames
    cs_n_out = ~dsp;
    sdi_out  = ~sdi_out;
    repeat (4) @(negedge clk_in);
  endtask : xfer

  task automatic release_port;
    @(negedge clk_in);
    cs_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask : release_port

  task automatic set_start(input logic v);
    @(negedge clk_in);
    start_n_out = v;
  endtask : set_start

endmodule : acs_host_model

`default_nettype wire

// [acs_ctrl_tb.sv]
// self-checking bench for the converter control block
// assumes acs_host_model plays the host and the bench feeds adc_result_in
`default_nettype none

module acs_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import acs_pkg::*;

  logic             clk_in = 1'b0;
  logic             reset_in = 1'b1;
  logic [RES_W-1:0] adc;
  logic             cs_n, sclk, sdi, fs, start_n;
  logic             sdo, sdo_oe, status, ref_int, pdiff, samp, conv, pd;
  logic [CMD_W-1:0] mux, mux_at;
  logic             stat_conv, samp_q, conv_q, sclk_q;
  int               samp_at, conv_at, conv_len;
  int               error_cnt = 0;
  int               comparisons = 0;

  always #5 clk_in = ~clk_in;

  acs_ctrl #(.FOUR_INPUT(1'b0)) acs_ctrl_i (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .cs_n_in(cs_n),
    .sclk_in(sclk),
    .sdi_in(sdi),
    .frame_sync_input_in(fs),
    .sample_start_pin_n_in(start_n),
    .adc_result_in(adc),
    .sdo_out(sdo),
    .sdo_oe_out(sdo_oe),
    .status_pin_out(status),
    .ref_internal_out(ref_int),
    .pseudo_diff_out(pdiff),
    .mux_sel_out(mux),
    .sampling_out(samp),
    .converting_out(conv),
    .powerdown_out(pd)
  );

  acs_host_model acs_host_model_i (
    .clk_in(clk_in),
    .sdo_in(sdo),
    .cs_n_out(cs_n),
    .sclk_out(sclk),
    .sdi_out(sdi),
    .fs_out(fs),
    .start_n_out(start_n)
  );

  // note at which active serial edge sampling and conversion begin
  always @(posedge clk_in)
  begin
    if (samp && !samp_q)
      samp_at = acs_host_model_i.edge_cnt;
    if (conv && !conv_q)
    begin
      conv_at  = acs_host_model_i.edge_cnt;
      mux_at   = mux;
      conv_len = 0;
    end
    if (conv)
      stat_conv = status;
    if (conv && sclk && !sclk_q)
      conv_len++;
    samp_q = samp;
    conv_q = conv;
    sclk_q = sclk;
  end

  function automatic logic [15:0] b16(input logic v);
    return {15'h0000, v};
  endfunction : b16

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic run(input logic [15:0] w, input bit dsp, input bit pause,
                     input bit pulse, output logic [15:0] rd);
    samp_at  = 99;
    conv_at  = 99;
    conv_len = 99;
    acs_host_model_i.xfer(w, dsp, pause, pulse, rd);
  endtask : run

  task automatic wr_cfg(input logic [11:0] c, input bit pause);
    logic [15:0] rd;
    run({CMD_CFG_WR, c}, 1'b0, pause, 1'b0, rd);
  endtask : wr_cfg

  task automatic rd_cfg(output logic [11:0] c);
    logic [15:0] rd;
    run({CMD_CFG_RD, 12'h000}, 1'b0, 1'b0, 1'b0, rd);
    c = rd[11:0];
  endtask : rd_cfg

  task automatic t_cfg;
    logic [11:0] c;
    chk("status_pin", 16'h0001, b16(status));
    wr_cfg(12'h000, 1'b0);
    rd_cfg(c);
    chk("cfg_reset", 16'h0000, {4'h0, c});
    wr_cfg(12'h884, 1'b1);
    chk("ref_internal", 16'h0001, b16(ref_int));
    chk("pseudo_diff", 16'h0001, b16(pdiff));
    chk("sdo_enable", 16'h0000, b16(sdo_oe));
    rd_cfg(c);
    chk("cfg_read", 16'h0884, {4'h0, c});
  endtask : t_cfg

  // k[0]: two's complement and long sampling, k[1]: half clock, int pin
  task automatic t_conv;
    logic [15:0]      rd;
    logic [RES_W-1:0] old;
    for (int k = 0; k < 4; k++)
    begin
      wr_cfg({1'b0, k[0], k[0], k[1], 5'h00, ~k[1], 2'h0}, 1'b0);
      adc = 10'h2A5 + RES_W'(k);
      run({4'(k), 12'h000}, 1'b0, 1'b0, 1'b0, rd);
      chk("sample_edge", 16'h0004, 16'(samp_at));
      chk("convert_edge", k[0] ? 16'h001C : 16'h0010, 16'(conv_at));
      chk("convert_len", k[1] ? 16'h0014 : 16'h000A, 16'(conv_len));
      chk("mux_sel", 16'(k), {12'h000, mux_at});
      chk("status_busy", b16(k[1]), b16(stat_conv));
      chk("status_done", b16(~k[1]), b16(status));
      old = adc;
      adc = adc ^ 10'h155;
      run({4'(k), 12'h000}, 1'b0, 1'b0, 1'b0, rd);
      chk("result", {6'h00, k[0] ? old ^ 10'h200 : old}, {6'h00, rd[15:6]});
    end
  endtask : t_conv

  task automatic t_dsp;
    logic [15:0] rd;
    wr_cfg(12'h000, 1'b0);
    adc = 10'h0F0;
    run(16'h1000, 1'b1, 1'b0, 1'b0, rd);
    chk("dsp_sample_edge", 16'h0004, 16'(samp_at));
    chk("dsp_convert_edge", 16'h0010, 16'(conv_at));
    adc = 10'h10F;
    run(16'h1000, 1'b1, 1'b0, 1'b0, rd);
    chk("dsp_result", 16'h00F0, {6'h00, rd[15:6]});
    acs_host_model_i.release_port();
  endtask : t_dsp

  task automatic t_ext;
    logic [15:0] rd;
    adc = 10'h3C3;
    acs_host_model_i.set_start(1'b0);
    repeat (90) @(negedge clk_in);
    chk("ext_sampling", 16'h0001, b16(samp));
    acs_host_model_i.set_start(1'b1);
    repeat (3) @(negedge clk_in);
    chk("ext_converting", 16'h0001, b16(conv));
    repeat (20) @(negedge clk_in);
    adc = 10'h000;
    run(16'h2000, 1'b0, 1'b0, 1'b0, rd);
    chk("ext_result", 16'h03C3, {6'h00, rd[15:6]});
  endtask : t_ext

  // start pin pulsed inside a power-down frame must not start sampling
  task automatic t_pd;
    logic [15:0] rd;
    logic [11:0] c;
    wr_cfg(12'hF84, 1'b0);
    run({CMD_PWR_DOWN, 12'h000}, 1'b0, 1'b0, 1'b1, rd);
    chk("pd_sample_edge", 16'h0063, 16'(samp_at));
    chk("powerdown", 16'h0001, b16(pd));
    rd_cfg(c);
    chk("cfg_kept", 16'h0F84, {4'h0, c});
  endtask : t_pd

  // four sweep orders of eight conversions fill the buffer, then drain it
  task automatic t_sweep;
    logic [15:0]      rd;
    logic [31:0]      seq [4] = '{32'h01234567, 32'h02460246,
                                  32'h00224666, 32'h02020202};
    logic [RES_W-1:0] q [$];
    for (int c = 0; c < 4; c++)
    begin
      wr_cfg({5'h00, 2'h2, c[1:0], 1'b1, 2'h0}, 1'b0);
      for (int k = 0; k < 8; k++)
      begin
        adc = {c[1:0], k[2:0], 5'h15};
        q.push_back(adc);
        run(16'h0000, 1'b0, 1'b0, 1'b0, rd);
        chk("sweep_mux", {12'h000, seq[c][31-4*k -: 4]}, {12'h000, mux_at});
      end
    end
    while (q.size() > 0)
    begin
      run({CMD_FIFO_RD, 12'h000}, 1'b0, 1'b0, 1'b0, rd);
      chk("fifo_word", {6'h00, q.pop_front()}, {6'h00, rd[15:6]});
    end
  endtask : t_sweep

  initial
  begin
    repeat (90000) @(posedge clk_in);
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    adc = 10'h000;
    repeat (20) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (2) @(negedge clk_in);
    t_cfg();
    t_conv();
    t_dsp();
    t_ext();
    t_pd();
    t_sweep();
    tally_and_finish();
  end

endmodule : acs_ctrl_tb

`default_nettype wire
